// ==== dacpwr_regs.sv ====
// DAC power, load detect, input readback and soft reset register bank
// How it works
// - Trim code with top bits set scales DAC output down, 0xC0 most.
// - Power control bit 0 puts DAC 1 in low power; resets zero.
// - Power control bit 1 puts DAC 2 in low power.
// - Bit 2 puts DAC 3 in low power; upper bits reserved zero.
// - Read-only register returns live secondary pixel bus; writes ignored.
// - Read-only register returns live luma pixel bus.
// - Read-only register returns live chroma pixel bus.
// - Writing one to reset bit 1 returns trim, low power and auto power-down to reset values.
// - Soft reset bit clears itself; later reads return zero.
`timescale 1ns/1ps
`include "dacpwr_params.svh"

module dacpwr_regs
    import dacpwr_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire dacpwr_req_s req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    input wire dacpwr_pix_s pix_i,
    input wire dacpwr_sync_s sync_i,
    input wire logic [1:0] load_absent_i,
    output logic [2:0] dac_low_power_o,
    output logic [1:0] dac_auto_down_o,
    output logic signed [7:0] trim_step_o,
    output logic trim_negative_o,
    output logic soft_reset_o
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic rst_meta;
    logic rst_sync;
    logic rst_n;
    dacpwr_state_e state;
    dacpwr_state_e next_state;
    logic [7:0] trim;
    logic [2:0] low_power;
    logic auto_pd;
    logic [7:0] next_rdata;
    logic wr_trim;
    logic wr_lowpwr;
    logic wr_load;
    logic wr_swrst;
    logic soft_pend;
    logic [7:0] load_word;
    logic [7:0] sync_word;

    // Power-on reset release through two flops
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    assign rst_n = rst_sync;

    assign wr_trim = req_i.wr && hit(req_i.addr, `DACPWR_OFF_TRIM);
    assign wr_lowpwr = req_i.wr && hit(req_i.addr, `DACPWR_OFF_LOWPWR);
    assign wr_load = req_i.wr && hit(req_i.addr, `DACPWR_OFF_LOAD);
    assign wr_swrst = req_i.wr && hit(req_i.addr, `DACPWR_OFF_SWRST)
                      && req_i.wdata[`DACPWR_SWRST_BIT];

    // Soft reset sequencer: one cycle of reset, then back to run
    assign soft_pend = (state == DACPWR_SWRST);
    always_comb begin
        case (state)
            DACPWR_RUN: next_state = wr_swrst ? DACPWR_SWRST : DACPWR_RUN;
            DACPWR_SWRST: next_state = DACPWR_RUN;
            default: next_state = DACPWR_RUN;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= DACPWR_RUN;
        end else begin
            state <= next_state;
        end
    end
    assign soft_reset_o = soft_pend;

    // Writable fields; soft reset returns them to reset values
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            trim <= `DACPWR_RST_TRIM;
            low_power <= `DACPWR_RST_LOWPWR;
            auto_pd <= `DACPWR_RST_AUTOPD;
        end else if (soft_pend) begin
            trim <= `DACPWR_RST_TRIM;
            low_power <= `DACPWR_RST_LOWPWR;
            auto_pd <= `DACPWR_RST_AUTOPD;
        end else begin
            if (wr_trim) begin
                trim <= req_i.wdata;
            end
            if (wr_lowpwr) begin
                // Reserved upper bits are not stored
                low_power <= req_i.wdata[`DACPWR_LOWPWR_MSB:0];
            end
            if (wr_load) begin
                auto_pd <= req_i.wdata[`DACPWR_AUTOPD_BIT];
            end
        end
    end

    assign dac_low_power_o = low_power;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_auto
            assign dac_auto_down_o[g] =
                auto_pd && load_absent_i[g];
        end
    endgenerate

    assign load_word = {3'h0, auto_pd, 2'h0, load_absent_i};
    assign sync_word = {2'h0, sync_i};

    always_comb begin
        next_rdata = 8'h00;
        case (req_i.addr)
            `DACPWR_OFF_TRIM: next_rdata = trim;
            `DACPWR_OFF_LOWPWR: next_rdata = {5'h00, low_power};
            `DACPWR_OFF_LOAD: next_rdata = load_word;
            `DACPWR_OFF_SNAP_S: next_rdata = pix_i.s;
            `DACPWR_OFF_SNAP_Y: next_rdata = pix_i.y;
            `DACPWR_OFF_SNAP_C: next_rdata = pix_i.c;
            `DACPWR_OFF_SYNC: next_rdata = sync_word;
            `DACPWR_OFF_SWRST: begin
                next_rdata = {6'h00, soft_pend, 1'b0};
            end
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rdata_o <= req_i.rd ? next_rdata : 8'h00;
            rvalid_o <= req_i.rd;
        end
    end

    dacpwr_gain_trim u_trim (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .code_i(trim),
        .step_o(trim_step_o),
        .negative_o(trim_negative_o)
    );

    AST_LOWPWR_DAC1: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wr_lowpwr && !soft_pend
        |=> dac_low_power_o[0] == $past(req_i.wdata[0]))
        else $error("DAC 1 low power bit not taken");
    AST_LOWPWR_DAC2: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wr_lowpwr && !soft_pend
        |=> dac_low_power_o[1] == $past(req_i.wdata[1]))
        else $error("DAC 2 low power bit not taken");
    AST_LOWPWR_DAC3: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wr_lowpwr && !soft_pend
        |=> dac_low_power_o[2] == $past(req_i.wdata[2]))
        else $error("DAC 3 low power bit not taken");
    AST_LOWPWR_RSVD: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_i.rd && req_i.addr == `DACPWR_OFF_LOWPWR
        |=> rdata_o[7:3] == 5'h00 && rdata_o[2:0] == $past(dac_low_power_o))
        else $error("Low power readback wrong");
    AST_SNAP_S: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_i.rd && req_i.addr == `DACPWR_OFF_SNAP_S
        |=> rdata_o == $past(pix_i.s))
        else $error("Secondary bus snapshot wrong");
    AST_SNAP_Y: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_i.rd && req_i.addr == `DACPWR_OFF_SNAP_Y
        |=> rdata_o == $past(pix_i.y) && rvalid_o)
        else $error("Luma bus snapshot wrong");
    AST_SNAP_C: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_i.rd && req_i.addr == `DACPWR_OFF_SNAP_C
        |=> rdata_o == $past(pix_i.c))
        else $error("Chroma bus snapshot wrong");
    AST_SWRST_CLEARS: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wr_swrst && state == DACPWR_RUN
        |=> soft_reset_o
        ##1 dac_low_power_o == 3'h0 && !auto_pd && trim == 8'h00)
        else $error("Soft reset did not clear registers");
    AST_SWRST_SELFCLR: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        soft_reset_o
        |=> !soft_reset_o)
        else $error("Soft reset bit did not clear itself");
    AST_SWRST_READ: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_i.rd && req_i.addr == `DACPWR_OFF_SWRST && !soft_reset_o
        |=> rdata_o == 8'h00)
        else $error("Soft reset register not read as zero");
    AST_AUTO_DOWN: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        dac_auto_down_o == (load_absent_i & {2{auto_pd}}))
        else $error("Auto power-down mismatch");
    AST_LOAD_READ: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_i.rd && req_i.addr == `DACPWR_OFF_LOAD
        |=> rdata_o[1:0] == $past(load_absent_i) && rdata_o[3:2] == 2'h0)
        else $error("Load status readback wrong");
    AST_SYNC_READ: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_i.rd && req_i.addr == `DACPWR_OFF_SYNC
        |=> rdata_o == {2'h0, $past(sync_i)})
        else $error("Control pin readback wrong");

    COV_SWRST: cover property (@(posedge clk_i) disable iff (!rst_n)
        wr_swrst ##1 soft_reset_o);
    COV_AUTO: cover property (@(posedge clk_i) disable iff (!rst_n)
        auto_pd && load_absent_i != 2'h0);
    COV_NEG_TRIM: cover property (@(posedge clk_i) disable iff (!rst_n)
        trim_negative_o);
    COV_WR_RD: cover property (@(posedge clk_i) disable iff (!rst_n)
        wr_lowpwr && req_i.rd);
endmodule : dacpwr_regs

// ==== dacpwr_params.svh ====
// Register offsets, field positions and reset values of the DAC power bank
`ifndef DACPWR_PARAMS_SVH
`define DACPWR_PARAMS_SVH

`define DACPWR_OFF_TRIM 8'h0B
`define DACPWR_OFF_LOWPWR 8'h0D
`define DACPWR_OFF_LOAD 8'h10
`define DACPWR_OFF_SNAP_S 8'h12
`define DACPWR_OFF_SNAP_Y 8'h13
`define DACPWR_OFF_SNAP_C 8'h14
`define DACPWR_OFF_SYNC 8'h16
`define DACPWR_OFF_SWRST 8'h17

`define DACPWR_RST_TRIM 8'h00
`define DACPWR_RST_LOWPWR 3'h0
`define DACPWR_RST_AUTOPD 1'b0

`define DACPWR_LOWPWR_MSB 2
`define DACPWR_AUTOPD_BIT 4
`define DACPWR_SWRST_BIT 1

`define DACPWR_TRIM_MAX_POS 8'sh40
`define DACPWR_TRIM_MAX_NEG 8'shC0

`endif

// ==== dacpwr_pkg.sv ====
// Types shared by the DAC power and readback register bank
package dacpwr_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dacpwr_req_s;

    typedef struct packed {
        logic [7:0] s;
        logic [7:0] y;
        logic [7:0] c;
    } dacpwr_pix_s;

    typedef struct packed {
        logic field_lock_or_serial_out_pin;
        logic sec_hsync;
        logic sec_vsync;
        logic pix_hsync;
        logic pix_vsync;
        logic pix_blank;
    } dacpwr_sync_s;

    typedef enum logic [1:0] {
        DACPWR_RUN = 2'b01,
        DACPWR_SWRST = 2'b10
    } dacpwr_state_e;
endpackage : dacpwr_pkg

// ==== dacpwr_gain_trim.sv ====
// Output level trim code to signed gain step decoder
`timescale 1ns/1ps
`include "dacpwr_params.svh"

module dacpwr_gain_trim
    import dacpwr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] code_i,
    output logic signed [7:0] step_o,
    output logic negative_o
);
    // Code is two's complement; one step is 1/64 of 7.5 percent
    logic signed [7:0] code_s;
    logic signed [7:0] next_step;

    assign code_s = $signed(code_i);
    // Out-of-table codes clamp to the ends
    assign next_step = (code_s > `DACPWR_TRIM_MAX_POS) ? `DACPWR_TRIM_MAX_POS :
                       (code_s < `DACPWR_TRIM_MAX_NEG) ? `DACPWR_TRIM_MAX_NEG :
                       code_s;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_o <= 8'sh00;
            negative_o <= 1'b0;
        end else begin
            step_o <= next_step;
            negative_o <= next_step[7];
        end
    end

    AST_NEG_TOP: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        code_i == 8'hC0
        |=> step_o == -8'sd64 && negative_o)
        else $error("Code C0 not most negative step");
    AST_NEG_LSB: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        code_i == 8'hFF
        |=> step_o == -8'sd1 && negative_o)
        else $error("All-ones code not smallest negative step");
endmodule : dacpwr_gain_trim

// ==== dacpwr_regs_tb.sv ====
// Self-checking random testbench of the DAC power and readback register bank
`timescale 1ns/1ps
`include "dacpwr_params.svh"

module testbench
    import dacpwr_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    dacpwr_req_s req_i = '0;
    dacpwr_pix_s pix_i = '0;
    dacpwr_sync_s sync_i = '0;
    logic [1:0] load_absent_i = 2'h0;
    logic [7:0] rdata_o;
    logic rvalid_o;
    logic [2:0] dac_low_power_o;
    logic [1:0] dac_auto_down_o;
    logic signed [7:0] trim_step_o;
    logic trim_negative_o;
    logic soft_reset_o;
    int num_errors = 0;
    int check_count = 0;
    logic [7:0] v;
    logic [7:0] e;
    logic ap;
    dacpwr_pix_s p;
    dacpwr_sync_s sy;
    logic [1:0] la;
    logic [7:0] codes [6] = '{8'hC0, 8'hFF, 8'hC1, 8'h80, 8'h40, 8'h7F};

    always #2 clk_i = ~clk_i;

    dacpwr_regs uut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .req_i(req_i),
        .rdata_o(rdata_o),
        .rvalid_o(rvalid_o),
        .pix_i(pix_i),
        .sync_i(sync_i),
        .load_absent_i(load_absent_i),
        .dac_low_power_o(dac_low_power_o),
        .dac_auto_down_o(dac_auto_down_o),
        .trim_step_o(trim_step_o),
        .trim_negative_o(trim_negative_o),
        .soft_reset_o(soft_reset_o)
    );

    task automatic finish_test;
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One strobe cycle; returns just after the edge that takes it
    task automatic access(input logic w, input logic r, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge clk_i);
        req_i <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk_i);
        req_i <= '0;
        #1;
    endtask : access

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        access(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        access(1'b0, 1'b1, a, 8'h00);
        chk({7'h0, rvalid_o}, 8'h01);
        chk(rdata_o, exp);
    endtask : rd_chk

    // Signed trim code clamped to the symmetric step range
    function automatic logic [7:0] trim_exp(input logic [7:0] c);
        int s;
        s = $signed(c);
        if (s > 64) s = 64;
        if (s < -64) s = -64;
        return s[7:0];
    endfunction : trim_exp

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        finish_test();
    end

    initial begin
        void'($urandom(32'hb8570705));
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_chk(`DACPWR_OFF_LOWPWR, 8'h00);
        rd_chk(`DACPWR_OFF_SWRST, 8'h00);
        rd_chk(`DACPWR_OFF_TRIM, 8'h00);
        rd_chk(8'h20, 8'h00);
        for (int i = 0; i < 12; i++) begin
            v = (i < 8) ? 8'(i) : 8'($urandom);
            wr(`DACPWR_OFF_LOWPWR, v);
            chk({7'h0, dac_low_power_o[0]}, {7'h0, v[0]});
            chk({5'h0, dac_low_power_o}, {5'h0, v[2:0]});
            rd_chk(`DACPWR_OFF_LOWPWR, {5'h0, v[2:0]});
        end
        for (int i = 0; i < 10; i++) begin
            v = (i < 6) ? codes[i] : 8'($urandom);
            e = trim_exp(v);
            wr(`DACPWR_OFF_TRIM, v);
            @(posedge clk_i);
            #1;
            chk(trim_step_o, e);
            chk({7'h0, trim_negative_o}, {7'h0, e[7]});
            rd_chk(`DACPWR_OFF_TRIM, v);
        end
        for (int i = 0; i < 8; i++) begin
            p = 24'($urandom);
            sy = 6'($urandom);
            la = 2'($urandom);
            ap = 1'(i);
            @(posedge clk_i);
            pix_i <= p;
            sync_i <= sy;
            load_absent_i <= la;
            wr(`DACPWR_OFF_SNAP_S, ~p.s);
            wr(`DACPWR_OFF_LOAD, {3'h7, ap, 4'hF});
            rd_chk(`DACPWR_OFF_SNAP_S, p.s);
            rd_chk(`DACPWR_OFF_SNAP_Y, p.y);
            rd_chk(`DACPWR_OFF_SNAP_C, p.c);
            rd_chk(`DACPWR_OFF_SYNC, {2'h0, sy});
            rd_chk(`DACPWR_OFF_LOAD, {3'h0, ap, 2'h0, la});
            chk({6'h0, dac_auto_down_o}, {6'h0, la & {2{ap}}});
        end
        // Same-cycle write and read: read shows the old value
        wr(`DACPWR_OFF_LOWPWR, 8'h07);
        access(1'b1, 1'b1, `DACPWR_OFF_LOWPWR, 8'h05);
        chk(rdata_o, 8'h07);
        chk({5'h0, dac_low_power_o}, 8'h05);
        wr(`DACPWR_OFF_SWRST, 8'h00);
        chk({7'h0, soft_reset_o}, 8'h00);
        rd_chk(`DACPWR_OFF_LOWPWR, 8'h05);
        wr(`DACPWR_OFF_LOAD, 8'h10);
        wr(`DACPWR_OFF_SWRST, 8'h02);
        chk({7'h0, soft_reset_o}, 8'h01);
        @(posedge clk_i);
        #1;
        chk({7'h0, soft_reset_o}, 8'h00);
        rd_chk(`DACPWR_OFF_SWRST, 8'h00);
        rd_chk(`DACPWR_OFF_LOWPWR, 8'h00);
        chk({5'h0, dac_low_power_o}, 8'h00);
        rd_chk(`DACPWR_OFF_TRIM, 8'h00);
        chk(trim_step_o, 8'h00);
        rd_chk(`DACPWR_OFF_LOAD, {6'h0, la});
        chk({6'h0, dac_auto_down_o}, 8'h00);
        // Back-to-back: read the reset bit during its one-cycle pulse
        wr(`DACPWR_OFF_LOWPWR, 8'h03);
        @(posedge clk_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: `DACPWR_OFF_SWRST, wdata: 8'h02};
        @(posedge clk_i);
        req_i <= '{wr: 1'b0, rd: 1'b1, addr: `DACPWR_OFF_SWRST, wdata: 8'h00};
        @(posedge clk_i);
        req_i <= '0;
        #1;
        chk(rdata_o, 8'h02);
        chk({5'h0, dac_low_power_o}, 8'h00);
        chk({7'h0, soft_reset_o}, 8'h00);
        finish_test();
    end
endmodule : testbench
